/* File: scpb_pkg.sv */
// shared constants and carrier types for the sleepy child poll buffer
`default_nettype none
package scpb_pkg;
    localparam int CLK_HZ = 25_000_000;
    localparam int POLL_PERIOD_MS = 100;
    localparam int POLL_CYCLES = (CLK_HZ / 1000) * POLL_PERIOD_MS;
    localparam int CHILD_SLOTS = 4;
    localparam int UNI_SLOTS = 4;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 32;
    localparam int CHAN_W = 16;
    localparam int RETRY_W = 24;
    localparam int POLL_TO_W = 32;
    localparam int BUF_TO_W = 32;
    localparam int UP_SLOTS = 2;
    localparam logic [2:0] SLEEP_MODE_PIN = 3'h1;
    localparam logic [2:0] SLEEP_MODE_CYC = 3'h4;
    localparam logic [2:0] SLEEP_MODE_CYC_PIN = 3'h5;
    localparam logic [3:0] CHAN_INDEX_RESET = 4'h0;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } scpb_pkt_s;

    typedef enum logic [2:0] {
        ED_SLEEP,
        ED_SCAN,
        ED_IDLE,
        ED_WAIT_ACK,
        ED_RX_DATA
    } scpb_ed_state_e;
endpackage
`default_nettype wire

/* File: scpb_slot.sv */
// one held packet slot with age timer
`default_nettype none
module scpb_slot (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    // control
    input wire logic load_i,
    input wire logic drop_i,
    input wire scpb_pkg::scpb_pkt_s pkt_i,
    input wire logic [scpb_pkg::BUF_TO_W-1:0] timeout_i,
    // state
    output logic valid_o,
    output scpb_pkg::scpb_pkt_s pkt_o
);
    logic [scpb_pkg::BUF_TO_W-1:0] age;
    wire expired = valid_o && (age >= timeout_i);

    always_ff @(posedge core_clk_i)
    begin
        if (sys_rst_i)
        begin
            valid_o <= 1'b0;
            age <= '0;
            pkt_o <= '0;
        end
        else if (load_i)
        begin
            valid_o <= 1'b1;
            age <= '0;
            pkt_o <= pkt_i;
        end
        else if (drop_i || expired)
        begin
            valid_o <= 1'b0;
            age <= '0;
        end
        else if (valid_o)
        begin
            age <= age + 1'b1;
        end
    end
endmodule
`default_nettype wire

/* File: scpb_top.sv */
// parent child table and buffering plus end-device poll and sleep sequencer
//
// Contract
// - child table holds children; joins refused when every entry is used
// - data for a known child is held only if a free slot exists
// - held packet kept until buffer timeout or child poll collects it; code also drops it when its child is removed from the table
// - only one broadcast held for all children
// - child collecting the broadcast gets its received flag set
// - broadcast freed once every child flag is set
// - new broadcast replaces old, clearing all received flags
// - child upstream data held until route exists, then sent
// - child not polling within poll timeout is removed
// - unknown destination type uses the short retransmission timeout
// - known end-device destination uses the extended retransmission timeout
// - end device supports pin sleep and cyclic sleep by mode setting
// - awake end device polls parent every 100 ms
// - receiver stays on after poll until acknowledgment arrives
// - pending ack keeps receiver on; otherwise receiver off till next poll
// - awake indicator low on entering sleep
// - with flow control, CTS high on entering sleep
// - asleep device ignores serial and radio traffic
// - on wake, awake indicator high and CTS low with flow control
// - unjoined device scans every configured channel after waking
// - sleep request high finishes current transfer then sleeps; low wakes
// - mode value 1 selects pin sleep
// - mode values 4 and 5 select cyclic sleep
`default_nettype none
module scpb_top (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    // parent configuration
    input wire logic [scpb_pkg::BUF_TO_W-1:0] buf_timeout_i,
    input wire logic [scpb_pkg::POLL_TO_W-1:0] poll_timeout_i,
    // child join and poll
    input wire logic join_req_i,
    input wire logic [scpb_pkg::ADDR_W-1:0] join_addr_i,
    output logic join_ok_o,
    input wire logic poll_req_i,
    input wire logic [scpb_pkg::ADDR_W-1:0] poll_addr_i,
    output logic poll_ack_o,
    output logic poll_pending_o,
    output logic poll_data_valid_o,
    output scpb_pkg::scpb_pkt_s poll_data_o,
    output logic [scpb_pkg::CHILD_SLOTS-1:0] child_used_o,
    // downstream data toward children
    input wire logic rx_valid_i,
    input wire logic rx_bcast_i,
    input wire scpb_pkg::scpb_pkt_s rx_pkt_i,
    output logic rx_ready_o,
    // upstream data from children
    input wire logic up_valid_i,
    input wire scpb_pkg::scpb_pkt_s up_pkt_i,
    input wire logic route_ok_i,
    input wire logic dest_is_ed_i,
    input wire logic tx_ready_i,
    output logic up_ready_o,
    output logic tx_valid_o,
    output scpb_pkg::scpb_pkt_s tx_pkt_o,
    input wire logic [scpb_pkg::RETRY_W-1:0] retry_short_i,
    input wire logic [scpb_pkg::RETRY_W-1:0] retry_ext_i,
    output logic [scpb_pkg::RETRY_W-1:0] retry_timeout_o,
    // end-device side
    input wire logic [2:0] sleep_mode_select_i,
    input wire logic flow_ctrl_enable_i,
    input wire logic sleep_request_pin_i,
    input wire logic cyc_wake_i,
    input wire logic cyc_sleep_i,
    input wire logic joined_i,
    input wire logic [scpb_pkg::CHAN_W-1:0] join_channel_list_i,
    input wire logic scan_done_i,
    input wire logic ack_rx_i,
    input wire logic ack_pending_i,
    input wire logic data_done_i,
    input wire logic serial_rx_i,
    input wire logic radio_rx_i,
    output logic poll_send_o,
    output logic rx_enable_o,
    output logic awake_o,
    output logic cts_n_o,
    output logic scan_start_o,
    output logic [3:0] scan_chan_o,
    output logic serial_accept_o,
    output logic radio_accept_o
);
    localparam int N = scpb_pkg::CHILD_SLOTS;
    localparam int U = scpb_pkg::UNI_SLOTS;

    ////////////////////////////////////////////////////////////////////////////
    // child table
    logic [scpb_pkg::ADDR_W-1:0] child_addr [N];
    logic [N-1:0] child_used;
    logic [N-1:0] got_bcast;
    logic [scpb_pkg::POLL_TO_W-1:0] child_age [N];
    logic [N-1:0] free_child;
    logic [N-1:0] poll_hit;
    logic [N-1:0] child_stale;
    logic [N-1:0] join_sel;
    logic [N-1:0] next_child_used;

    assign free_child = ~child_used;
    assign join_sel = free_child & ~(free_child - 1'b1);
    assign join_ok_o = join_req_i && (free_child != '0);
    assign child_used_o = child_used;

    genvar gi;
    generate
        for (gi = 0; gi < N; gi++)
        begin : g_child
            assign poll_hit[gi] = poll_req_i && child_used[gi] && child_addr[gi] == poll_addr_i;
            assign child_stale[gi] = child_used[gi] && child_age[gi] >= poll_timeout_i;
            assign next_child_used[gi] = (child_used[gi] && !child_stale[gi])
                || (join_ok_o && join_sel[gi]);
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // broadcast slot
    logic bc_valid;
    scpb_pkg::scpb_pkt_s bc_pkt;
    wire bc_load = rx_valid_i && rx_bcast_i;
    wire [N-1:0] bc_collect = poll_hit & {N{bc_valid}} & ~got_bcast;
    wire [N-1:0] flags_after = got_bcast | bc_collect;
    wire bc_all = bc_valid && child_used != '0 && ((flags_after | ~child_used) == '1);

    ////////////////////////////////////////////////////////////////////////////
    // unicast slots
    logic [U-1:0] u_valid;
    scpb_pkg::scpb_pkt_s u_pkt [U];
    logic [U-1:0] u_load;
    logic [U-1:0] u_drop;
    logic [U-1:0] u_match;
    logic [U-1:0] u_orphan;
    logic [N-1:0] rx_child_hit;
    wire [U-1:0] u_free = ~u_valid;
    wire [U-1:0] u_first_free = u_free & ~(u_free - 1'b1);
    wire rx_for_child = rx_child_hit != '0;
    wire uni_rx = rx_valid_i && !rx_bcast_i && rx_for_child;
    wire [U-1:0] u_first_match = u_match & ~(u_match - 1'b1);

    generate
        for (gi = 0; gi < N; gi++)
        begin : g_rxhit
            assign rx_child_hit[gi] = child_used[gi] && child_addr[gi] == rx_pkt_i.addr;
        end
        for (gi = 0; gi < U; gi++)
        begin : g_uni
            logic owned;
            always_comb
            begin
                owned = 1'b0;
                for (int k = 0; k < N; k++)
                begin
                    if (next_child_used[k] && !(join_ok_o && join_sel[k])
                        && child_addr[k] == u_pkt[gi].addr)
                    begin
                        owned = 1'b1;
                    end
                end
            end
            assign u_match[gi] = u_valid[gi] && poll_req_i && u_pkt[gi].addr == poll_addr_i;
            assign u_orphan[gi] = u_valid[gi] && !owned;
            assign u_load[gi] = uni_rx && u_first_free[gi];
            assign u_drop[gi] = u_first_match[gi] || u_orphan[gi];
            scpb_slot u_slot (
                .core_clk_i(core_clk_i),
                .sys_rst_i(sys_rst_i),
                .load_i(u_load[gi]),
                .drop_i(u_drop[gi]),
                .pkt_i(rx_pkt_i),
                .timeout_i(buf_timeout_i),
                .valid_o(u_valid[gi]),
                .pkt_o(u_pkt[gi])
            );
        end
    endgenerate

    // unicast refused when no slot free; broadcast always taken (replaces old)
    assign rx_ready_o = rx_bcast_i || (u_free != '0 && rx_for_child);

    ////////////////////////////////////////////////////////////////////////////
    // poll answer
    scpb_pkg::scpb_pkt_s next_poll_data;
    logic next_poll_valid;
    wire any_poll = poll_hit != '0;
    always_comb
    begin
        next_poll_data = '0;
        next_poll_valid = 1'b0;
        for (int k = 0; k < U; k++)
        begin
            if (u_first_match[k])
            begin
                next_poll_data = u_pkt[k];
                next_poll_valid = 1'b1;
            end
        end
        if (!next_poll_valid && bc_collect != '0)
        begin
            next_poll_data = bc_pkt;
            next_poll_valid = 1'b1;
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (sys_rst_i)
        begin
            child_used <= '0;
            got_bcast <= '0;
            bc_valid <= 1'b0;
            bc_pkt <= '0;
            poll_ack_o <= 1'b0;
            poll_pending_o <= 1'b0;
            poll_data_valid_o <= 1'b0;
            poll_data_o <= '0;
            for (int k = 0; k < N; k++)
            begin
                child_addr[k] <= '0;
                child_age[k] <= '0;
            end
        end
        else
        begin
            child_used <= next_child_used;
            poll_ack_o <= any_poll;
            poll_pending_o <= any_poll && next_poll_valid;
            poll_data_valid_o <= any_poll && next_poll_valid;
            poll_data_o <= next_poll_data;
            for (int k = 0; k < N; k++)
            begin
                if (join_ok_o && join_sel[k])
                begin
                    child_addr[k] <= join_addr_i;
                    child_age[k] <= '0;
                end
                else if (poll_hit[k] || !child_used[k])
                begin
                    child_age[k] <= '0;
                end
                else
                begin
                    child_age[k] <= child_age[k] + 1'b1;
                end
            end
            if (bc_load)
            begin
                bc_valid <= 1'b1;
                bc_pkt <= rx_pkt_i;
                got_bcast <= '0;
            end
            else if (bc_all)
            begin
                bc_valid <= 1'b0;
                got_bcast <= '0;
            end
            else
            begin
                got_bcast <= flags_after & next_child_used;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // upstream hold and retransmission timeout
    logic up_full;
    scpb_pkg::scpb_pkt_s up_pkt;
    assign up_ready_o = !up_full;
    assign tx_valid_o = up_full && route_ok_i;
    assign tx_pkt_o = up_pkt;
    assign retry_timeout_o = dest_is_ed_i ? retry_ext_i : retry_short_i;

    always_ff @(posedge core_clk_i)
    begin
        if (sys_rst_i)
        begin
            up_full <= 1'b0;
            up_pkt <= '0;
        end
        else if (up_valid_i && !up_full)
        begin
            up_full <= 1'b1;
            up_pkt <= up_pkt_i;
        end
        else if (tx_valid_o && tx_ready_i)
        begin
            up_full <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // end-device sleep and poll sequencer
    scpb_pkg::scpb_ed_state_e ed_state, next_ed_state;
    logic [$clog2(scpb_pkg::POLL_CYCLES)-1:0] poll_cnt;
    logic sleep_req_q;
    logic [3:0] scan_idx;

    wire mode_pin = sleep_mode_select_i == scpb_pkg::SLEEP_MODE_PIN;
    wire mode_cyc = sleep_mode_select_i == scpb_pkg::SLEEP_MODE_CYC
        || sleep_mode_select_i == scpb_pkg::SLEEP_MODE_CYC_PIN;
    wire pin_fall = sleep_req_q && !sleep_request_pin_i;
    wire want_sleep = (mode_pin && sleep_request_pin_i) || (mode_cyc && cyc_sleep_i);
    wire want_wake = (mode_pin && !sleep_request_pin_i) || (mode_cyc && cyc_wake_i)
        || (sleep_mode_select_i == scpb_pkg::SLEEP_MODE_CYC_PIN && pin_fall);
    wire is_awake = ed_state != scpb_pkg::ED_SLEEP;
    wire poll_tick = poll_cnt == '0;

    always_comb
    begin
        next_ed_state = ed_state;
        case (ed_state)
            scpb_pkg::ED_SLEEP:
                if (want_wake)
                    next_ed_state = joined_i ? scpb_pkg::ED_IDLE : scpb_pkg::ED_SCAN;
            scpb_pkg::ED_SCAN:
                if (scan_done_i)
                    next_ed_state = want_sleep ? scpb_pkg::ED_SLEEP : scpb_pkg::ED_IDLE;
            scpb_pkg::ED_IDLE:
                if (want_sleep)
                    next_ed_state = scpb_pkg::ED_SLEEP;
                else if (poll_tick)
                    next_ed_state = scpb_pkg::ED_WAIT_ACK;
            scpb_pkg::ED_WAIT_ACK:
                if (ack_rx_i)
                    next_ed_state = ack_pending_i ? scpb_pkg::ED_RX_DATA
                        : scpb_pkg::ED_IDLE;
            scpb_pkg::ED_RX_DATA:
                if (data_done_i)
                    next_ed_state = scpb_pkg::ED_IDLE;
            default:
                next_ed_state = scpb_pkg::ED_SLEEP;
        endcase
    end

    assign rx_enable_o = ed_state == scpb_pkg::ED_WAIT_ACK
        || ed_state == scpb_pkg::ED_RX_DATA;
    assign serial_accept_o = is_awake && serial_rx_i;
    assign radio_accept_o = is_awake && radio_rx_i;

    always_ff @(posedge core_clk_i)
    begin
        if (sys_rst_i)
        begin
            ed_state <= scpb_pkg::ED_SLEEP;
            poll_cnt <= '0;
            sleep_req_q <= 1'b0;
            awake_o <= 1'b0;
            cts_n_o <= 1'b1;
            poll_send_o <= 1'b0;
            scan_start_o <= 1'b0;
            scan_idx <= scpb_pkg::CHAN_INDEX_RESET;
            scan_chan_o <= scpb_pkg::CHAN_INDEX_RESET;
        end
        else
        begin
            ed_state <= next_ed_state;
            sleep_req_q <= sleep_request_pin_i;
            awake_o <= next_ed_state != scpb_pkg::ED_SLEEP;
            cts_n_o <= !(next_ed_state != scpb_pkg::ED_SLEEP
                && flow_ctrl_enable_i);
            poll_send_o <= ed_state == scpb_pkg::ED_IDLE
                && next_ed_state == scpb_pkg::ED_WAIT_ACK;
            if (ed_state != scpb_pkg::ED_IDLE || poll_tick)
                poll_cnt <= 22'(scpb_pkg::POLL_CYCLES - 1);
            else
                poll_cnt <= poll_cnt - 1'b1;
            scan_start_o <= 1'b0;
            if (ed_state == scpb_pkg::ED_SCAN && !scan_done_i)
            begin
                // walk every channel enabled in the list
                scan_idx <= scan_idx + 1'b1;
                if (join_channel_list_i[scan_idx])
                begin
                    scan_chan_o <= scan_idx;
                    scan_start_o <= 1'b1;
                end
            end
            else
            begin
                scan_idx <= scpb_pkg::CHAN_INDEX_RESET;
            end
        end
    end
endmodule
`default_nettype wire

/* File: scpb_chk.sv */
// concurrent checks on the top ports of the poll buffer
`default_nettype none
module scpb_chk (
    // clock, reset and control
    input wire logic core_clk_i, sys_rst_i, join_req_i, join_ok_o, poll_req_i, poll_ack_o,
    input wire logic rx_valid_i, rx_bcast_i, rx_ready_o, tx_valid_o, route_ok_i,
    input wire logic dest_is_ed_i, flow_ctrl_enable_i, awake_o, cts_n_o, serial_accept_o,
    input wire logic radio_accept_o, poll_send_o, rx_enable_o, ack_rx_i, ack_pending_i,
    // buses
    input wire logic [scpb_pkg::CHILD_SLOTS-1:0] child_used_o,
    input wire logic [scpb_pkg::RETRY_W-1:0] retry_short_i, retry_ext_i, retry_timeout_o
);
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (sys_rst_i);
    ////////////////////////////////////////////////////////////////////////////////
    a_join_full: assert property (join_req_i && &child_used_o |-> !join_ok_o)
        else $error("join accepted with a full table");
    a_ack_cause: assert property (poll_ack_o |-> $past(poll_req_i))
        else $error("poll answer without a poll");
    a_bcast_taken: assert property (rx_valid_i && rx_bcast_i |-> rx_ready_o)
        else $error("broadcast refused");
    a_tx_route: assert property (tx_valid_o |-> route_ok_i)
        else $error("upstream sent without a route");
    a_retry_sel: assert property (retry_timeout_o == (dest_is_ed_i ? retry_ext_i
        : retry_short_i))
        else $error("wrong retransmission timeout");
    a_sleep_cts: assert property (!awake_o |-> cts_n_o)
        else $error("cts low while asleep");
    a_wake_cts: assert property ($rose(awake_o) && flow_ctrl_enable_i |-> !cts_n_o)
        else $error("cts not low on wake");
    a_asleep_deaf: assert property (!awake_o |-> !serial_accept_o && !radio_accept_o)
        else $error("traffic accepted while asleep");
    a_rx_wait: assert property (poll_send_o |-> rx_enable_o)
        else $error("receiver off after poll");
    a_rx_off: assert property (rx_enable_o && ack_rx_i && !ack_pending_i |=> !rx_enable_o)
        else $error("receiver left on without pending data");
    c_join_full: cover property (join_req_i && &child_used_o);
    c_wake: cover property ($rose(awake_o));
    c_tx: cover property (tx_valid_o);
endmodule
bind scpb_top scpb_chk u_chk (.*);
`default_nettype wire

/* File: scpb_partner.sv */
// host controller and parent radio node facing the end device
`default_nettype none
module scpb_partner (
    // clock and device outputs
    input wire logic core_clk_i, poll_send_i, cts_n_i, scan_start_i,
    // bench commands
    input wire logic sleep_cmd_i, pend_cmd_i, host_data_i,
    // pin, ack, pending, serial, scan done, data done
    output logic [5:0] far_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] dly = 2'h0;
    logic [4:0] scnt = 5'h0;
    logic pin = 1'h1, ack = 1'h0, pend = 1'h0, ser = 1'h0, scan = 1'h0, done = 1'h0;
    assign far_o = {pin, ack, pend, ser, scan, done};
    always @(negedge core_clk_i)
    begin
        pin <= sleep_cmd_i;
        ser <= host_data_i && !cts_n_i;
        dly <= {dly[0], poll_send_i};
        ack <= dly[1];
        // flag has no meaning outside an ack
        pend <= dly[1] ? pend_cmd_i : !pend;
        done <= ack && pend;
        // scan done once all sixteen channel steps have passed
        if (scnt != 5'h0)
            scnt <= (scnt == 5'h10) ? 5'h0 : scnt + 5'h1;
        else if (scan_start_i)
            scnt <= 5'h1;
        scan <= scnt == 5'h0f;
    end
endmodule
`default_nettype wire

/* File: tb.sv */
// self-checking bench for the poll buffer
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk_i = 1'h0;
    logic sys_rst_i = 1'h1;
    logic [31:0] buf_timeout_i, poll_timeout_i;
    logic [15:0] join_addr_i, poll_addr_i, join_channel_list_i, chans;
    logic [23:0] retry_short_i, retry_ext_i, retry_timeout_o;
    logic [2:0] sleep_mode_select_i;
    logic [3:0] child_used_o, scan_chan_o;
    scpb_pkg::scpb_pkt_s rx_pkt_i, up_pkt_i, poll_data_o, tx_pkt_o, p;
    logic join_req_i, poll_req_i, rx_valid_i, rx_bcast_i, up_valid_i, route_ok_i, dest_is_ed_i;
    logic tx_ready_i, flow_ctrl_enable_i, cyc_wake_i, cyc_sleep_i, joined_i, radio_rx_i;
    logic join_ok_o, poll_ack_o, poll_pending_o, poll_data_valid_o, rx_ready_o, up_ready_o;
    logic tx_valid_o, poll_send_o, rx_enable_o, awake_o, cts_n_o, scan_start_o;
    logic serial_accept_o, radio_accept_o, sleep_cmd, pend_cmd, host_data;
    wire logic [5:0] far;
    wire logic sleep_request_pin_i = far[5], ack_rx_i = far[4], ack_pending_i = far[3];
    wire logic serial_rx_i = far[2], scan_done_i = far[1], data_done_i = far[0];
    int errors = 0, check_count = 0, seed = 19774, i;
    scpb_pkg::scpb_pkt_s exp_q[$], tx_q[$];
    always #20 core_clk_i = ~core_clk_i;
    scpb_top DUT (.*);
    scpb_partner u_far (.core_clk_i, .poll_send_i(poll_send_o), .cts_n_i(cts_n_o),
        .scan_start_i(scan_start_o), .sleep_cmd_i(sleep_cmd), .pend_cmd_i(pend_cmd),
        .host_data_i(host_data), .far_o(far));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input string name, input logic [63:0] seen, exp);
        check_count++;
        if (seen !== exp)
        begin
            errors++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic summarize;
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic wait_awake(input logic want);
        int n;
        for (n = 0; awake_o !== want; n++)
        begin
            if (n == 60)
            begin
                errors++;
                summarize;
            end
            @(negedge core_clk_i);
        end
    endtask
    task automatic do_join(input logic [15:0] a, input logic ok);
        @(negedge core_clk_i);
        join_req_i = 1'h1;
        join_addr_i = a;
        #1 check("join_ok_o", join_ok_o, ok);
        @(negedge core_clk_i);
        join_req_i = 1'h0;
    endtask
    task automatic poll(input logic [15:0] a, input logic pd);
        @(negedge core_clk_i);
        poll_req_i = 1'h1;
        poll_addr_i = a;
        @(negedge core_clk_i);
        poll_req_i = 1'h0;
        check("poll_ack_o", poll_ack_o, 1'h1);
        check("poll_pending_o", poll_pending_o, pd);
    endtask
    task automatic send(input logic bc, input scpb_pkg::scpb_pkt_s d, input logic rdy);
        @(negedge core_clk_i);
        rx_valid_i = 1'h1;
        rx_bcast_i = bc;
        rx_pkt_i = d;
        #1 check("rx_ready_o", rx_ready_o, rdy);
        @(negedge core_clk_i);
        rx_valid_i = 1'h0;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    always @(negedge core_clk_i)
        if (poll_data_valid_o === 1'h1)
            check("poll_data_o", poll_data_o, exp_q.pop_front());
    always @(posedge core_clk_i)
        if (tx_valid_o === 1'h1 && tx_ready_i === 1'h1)
            check("tx_pkt_o", tx_pkt_o, tx_q.pop_front());
    initial
    begin
        {join_req_i, poll_req_i, rx_valid_i, rx_bcast_i, up_valid_i, route_ok_i, dest_is_ed_i,
            tx_ready_i, flow_ctrl_enable_i, cyc_wake_i, cyc_sleep_i, joined_i, radio_rx_i,
            pend_cmd, host_data} = '0;
        {join_addr_i, poll_addr_i, rx_pkt_i, up_pkt_i, retry_short_i, retry_ext_i} = '0;
        sleep_cmd = 1'h1;
        buf_timeout_i = 32'h0001_0000;
        poll_timeout_i = 32'h0001_0000;
        join_channel_list_i = 16'($random(seed)) | 16'h0001;
        sleep_mode_select_i = scpb_pkg::SLEEP_MODE_PIN;
        repeat (6) @(negedge core_clk_i);
        sys_rst_i = 1'h0;
        for (i = 0; i < 5; i++)
            do_join(16'h1000 + 16'(i), i < 4);
        check("child_used_o", child_used_o, 4'hf);
        p = {16'h1000, 32'($random(seed))};
        send(1'h0, p, 1'h1);
        exp_q.push_back(p);
        send(1'h0, {16'h0bad, p.data}, 1'h0);
        poll(16'h1000, 1'h1);
        poll(16'h1000, 1'h0);
        for (i = 0; i < 5; i++)
        begin
            p = {16'h1001, 32'($random(seed))};
            send(1'h0, p, i < 4);
            if (i < 4)
                exp_q.push_back(p);
        end
        for (i = 0; i < 4; i++)
            poll(16'h1001, 1'h1);
        buf_timeout_i = 32'h0000_0020;
        send(1'h0, {16'h1002, p.data}, 1'h1);
        repeat (64) @(negedge core_clk_i);
        poll(16'h1002, 1'h0);
        buf_timeout_i = 32'h0001_0000;
        p = {16'hffff, 32'($random(seed))};
        send(1'h1, p, 1'h1);
        exp_q.push_back(p);
        poll(16'h1000, 1'h1);
        poll(16'h1000, 1'h0);
        p.data = ~p.data;
        send(1'h1, p, 1'h1);
        for (i = 0; i < 5; i++)
        begin
            if (i < 4)
                exp_q.push_back(p);
            poll(16'h1000 + 16'(i % 4), i < 4);
        end
        send(1'h0, {16'h1003, p.data}, 1'h1);
        poll_timeout_i = 32'h0000_0040;
        for (i = 0; child_used_o !== 4'h0 && i < 300; i++)
            @(negedge core_clk_i);
        check("child_used_o", child_used_o, 4'h0);
        poll_timeout_i = 32'h0001_0000;
        do_join(16'h1003, 1'h1);
        poll(16'h1003, 1'h0);
        p = {16'h2000, 32'($random(seed))};
        @(negedge core_clk_i);
        up_valid_i = 1'h1;
        up_pkt_i = p;
        #1 check("up_ready_o", up_ready_o, 1'h1);
        @(negedge core_clk_i);
        up_valid_i = 1'h0;
        repeat (4) @(negedge core_clk_i);
        check("tx_valid_o", tx_valid_o, 1'h0);
        check("up_ready_o", up_ready_o, 1'h0);
        tx_q.push_back(p);
        route_ok_i = 1'h1;
        tx_ready_i = 1'h1;
        #1 check("tx_valid_o", tx_valid_o, 1'h1);
        @(negedge core_clk_i);
        tx_ready_i = 1'h0;
        for (i = 0; i < 4; i++)
        begin
            @(negedge core_clk_i);
            dest_is_ed_i = i[0];
            retry_short_i = 24'($random(seed));
            retry_ext_i = 24'($random(seed));
            #1 check("retry_timeout_o", retry_timeout_o,
                i[0] ? retry_ext_i : retry_short_i);
        end
        @(negedge core_clk_i);
        flow_ctrl_enable_i = 1'h1;
        cyc_wake_i = 1'h1;
        repeat (4) @(negedge core_clk_i);
        check("awake_o", awake_o, 1'h0);
        check("cts_n_o", cts_n_o, 1'h1);
        cyc_wake_i = 1'h0;
        sleep_cmd = 1'h0;
        wait_awake(1'h1);
        check("cts_n_o", cts_n_o, 1'h0);
        chans = 16'h0000;
        repeat (100)
        begin
            @(negedge core_clk_i);
            if (scan_start_o === 1'h1)
                chans[scan_chan_o] = 1'h1;
        end
        check("scanned", chans, join_channel_list_i);
        joined_i = 1'h1;
        host_data = 1'h1;
        radio_rx_i = 1'h1;
        sleep_cmd = 1'h1;
        wait_awake(1'h0);
        check("cts_n_o", cts_n_o, 1'h1);
        check("radio_accept_o", radio_accept_o, 1'h0);
        flow_ctrl_enable_i = 1'h0;
        for (i = 0; i < 2; i++)
        begin
            sleep_mode_select_i = i ? scpb_pkg::SLEEP_MODE_CYC_PIN : scpb_pkg::SLEEP_MODE_CYC;
            cyc_wake_i = 1'h1;
            wait_awake(1'h1);
            check("cts_n_o", cts_n_o, 1'h1);
            cyc_wake_i = 1'h0;
            cyc_sleep_i = 1'h1;
            wait_awake(1'h0);
            cyc_sleep_i = 1'h0;
        end
        summarize;
    end
endmodule
`default_nettype wire
